/* hdl/cphy_regs.sv */
// cphy_regs: AHB-Lite register bank controlling an integrated CAN
// transceiver front end, with sticky event flags and one interrupt line.
// assumes: front-end levels are asynchronous; special_mode is a static
// level from chip control; one AHB-Lite master, word accesses only.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R01 - eight registers are decoded at consecutive word offsets 0x0000 to 0x001C.
// R02 - port_data bit 7 reads a synchronised copy of the wake receiver output.
// R03 - when routed, port_data bit 1 drives the transmit input, 0 low, 1 high.
// R04 - port_data bit 0 reads a synchronised copy of the receive output.
// R05 - writing one to phy_on brings the transceiver out of shutdown.
// R06 - while phy_on is zero the transceiver stays in shutdown.
// R07 - phy_on is set once only while all other control bits stay writable.
// R08 - termination_bias_on drives the mid bias when enabled and active.
// R09 - a nonzero wake_filter_sel enables the wake receiver outside shutdown.
// R10 - wake_filter_sel picks no filtering, one masked or two masked events.
// R11 - software should set wake_filter_sel to zero when wake is unused.
// R12 - slew_sel picks one of six rates and software avoids codes 011 and 111.
// R13 - factory test registers reset to zero and take writes in special mode.
// R14 - port_data reads and writes any time and only bit 1 is writable.
// R15 - on the transmit input one is recessive and zero is dominant.
// R16 - writing one to an irq_flags bit clears it and zero leaves it.
// R17 - unimplemented bits read zero and ignore writes.
module cphy_regs (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [cphy_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic special_mode,
	input wire logic tx_from_port,
	input wire logic can_tx_in,
	input wire logic phy_rx_out,
	input wire logic wake_rx_out,
	input wire logic [4:0] bus_fault_status,
	input wire logic [1:0] over_current,
	output logic phy_tx_in,
	output logic phy_on,
	output logic termination_bias_on,
	output logic termination_bias_oe,
	output logic wake_rx_enable,
	output logic [1:0] wake_filter_sel,
	output logic [2:0] slew_sel,
	output logic [7:0] factory_test_a,
	output logic [7:0] factory_test_b,
	output logic [7:0] factory_test_c,
	output logic irq
);
	// two over-current, five status, wake and receive levels
	localparam int NSYNC = 9;
	typedef struct packed {
		logic wr_pend;
		logic [2:0] wr_idx;
		logic [31:0] rdata;
		logic [7:0] ctrl;
		logic tx_direct;
		logic [7:0] test_a;
		logic [7:0] test_b;
		logic [7:0] test_c;
		logic [7:0] irq_en;
		logic [7:0] flags;
		logic [4:0] status_prev;
		logic tx_out;
		logic bias_oe;
		logic wake_en;
		logic irq;
	} cphy_state_t;

	cphy_state_t st_reg;
	cphy_state_t st_next;
	logic [NSYNC-1:0] sync_out;
	logic addr_phase;
	logic [2:0] a_idx;
	logic [7:0] wbyte;
	logic [7:0] status_now;
	logic [7:0] port_now;
	logic [7:0] flag_set;
	logic [7:0] rd_byte;
	logic active;

	cphy_sync_if #(.W(NSYNC)) sif ();

	// pins from the analogue side cross into hclk before any decoding
	assign sif.raw = {over_current, bus_fault_status, wake_rx_out,
		phy_rx_out};

	cphy_sync #(.W(NSYNC)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.sif(sif)
	);
	assign sync_out = sif.synced;

	always_comb begin
		addr_phase = hsel && hready && htrans == cphy_pkg::HTRANS_NONSEQ;
		// R01 word index decode
		a_idx = haddr[4:2];
		wbyte = hwdata[7:0];
		status_now = {sync_out[6:2], 3'h0} & cphy_pkg::STATUS_MASK;
		port_now = 8'h00;
		// R02 wake level read
		port_now[cphy_pkg::POS_WAKE_RX] = sync_out[1];
		port_now[cphy_pkg::POS_TX_DIRECT] = st_reg.tx_direct;
		// R04 receive level read
		port_now[cphy_pkg::POS_RX] = sync_out[0];
		// events: each change of status bits 7-4, a rising timeout or an over-current sets a sticky flag
		flag_set = 8'h00;
		flag_set[7:4] = sync_out[6:3] ^ st_reg.status_prev[4:1];
		flag_set[cphy_pkg::POS_DT] = sync_out[2] && !st_reg.status_prev[0];
		flag_set[cphy_pkg::POS_HOC] = sync_out[8];
		flag_set[cphy_pkg::POS_LOC] = sync_out[7];
		// R17 unimplemented bits read zero
		unique case (a_idx)
			cphy_pkg::IDX_PORT_DATA: rd_byte = port_now;
			cphy_pkg::IDX_PHY_CONTROL: rd_byte = st_reg.ctrl;
			cphy_pkg::IDX_FACTORY_TEST_A: rd_byte = st_reg.test_a;
			cphy_pkg::IDX_PHY_STATUS: rd_byte = status_now;
			cphy_pkg::IDX_FACTORY_TEST_B: rd_byte = st_reg.test_b;
			cphy_pkg::IDX_FACTORY_TEST_C: rd_byte = st_reg.test_c;
			cphy_pkg::IDX_IRQ_ENABLE: rd_byte = st_reg.irq_en;
			cphy_pkg::IDX_IRQ_FLAGS: rd_byte = st_reg.flags;
		endcase
		active = st_reg.ctrl[cphy_pkg::POS_PHY_ON];

		st_next = st_reg;
		st_next.status_prev = sync_out[6:2];
		// capture address phase; write data lands in the next cycle
		st_next.wr_pend = addr_phase && hwrite;
		st_next.wr_idx = a_idx;
		if (addr_phase && !hwrite) begin
			st_next.rdata = {24'h0, rd_byte};
		end
		if (st_reg.wr_pend) begin
			unique case (st_reg.wr_idx)
				cphy_pkg::IDX_PORT_DATA: begin
					// R14 only bit 1 writable
					st_next.tx_direct = wbyte[cphy_pkg::POS_TX_DIRECT];
				end
				cphy_pkg::IDX_PHY_CONTROL: begin
					// R07 phy_on set once
					st_next.ctrl = (wbyte & cphy_pkg::CTRL_WMASK) |
						{st_reg.ctrl[cphy_pkg::POS_PHY_ON] |
						wbyte[cphy_pkg::POS_PHY_ON], 7'h00};
				end
				cphy_pkg::IDX_FACTORY_TEST_A: begin
					// R13 special mode only
					if (special_mode) begin
						st_next.test_a = wbyte;
					end
				end
				cphy_pkg::IDX_FACTORY_TEST_B: begin
					if (special_mode) begin
						st_next.test_b = wbyte;
					end
				end
				cphy_pkg::IDX_FACTORY_TEST_C: begin
					if (special_mode) begin
						st_next.test_c = wbyte;
					end
				end
				cphy_pkg::IDX_IRQ_ENABLE: begin
					st_next.irq_en = wbyte & cphy_pkg::IRQ_EN_MASK;
				end
				cphy_pkg::IDX_IRQ_FLAGS: begin
					// R16 write one clears
					st_next.flags = st_reg.flags & ~wbyte;
				end
				cphy_pkg::IDX_PHY_STATUS: begin
				end
			endcase
		end
		// a flag raised in the clearing cycle survives the clear
		st_next.flags = (st_next.flags | flag_set) & cphy_pkg::IRQ_FLAG_MASK;
		// R03 port drives transmit input when routed
		// R15 one recessive, zero dominant; shutdown parks it recessive
		st_next.tx_out = !active ? 1'b1 :
			(tx_from_port ? st_reg.tx_direct : can_tx_in);
		// R08 bias only while enabled
		st_next.bias_oe = active &&
			st_reg.ctrl[cphy_pkg::POS_TERM_BIAS];
		// R09 wake receiver enable
		st_next.wake_en = active &&
			st_reg.ctrl[cphy_pkg::POS_WAKE_SEL +: 2] != cphy_pkg::WAKE_OFF;
		// voltage enable covers bits 7-4, timeout bit 3, over-current 1-0
		st_next.irq = ((|(st_reg.flags[7:4])) && st_reg.irq_en[4]) ||
			(st_reg.flags[cphy_pkg::POS_DT] && st_reg.irq_en[3]) ||
			((|(st_reg.flags[1:0])) && st_reg.irq_en[0]);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
			st_reg.ctrl <= cphy_pkg::RST_CONTROL;
			st_reg.tx_direct <= cphy_pkg::RST_TX_DIRECT;
			st_reg.test_a <= cphy_pkg::RST_TEST;
			st_reg.test_b <= cphy_pkg::RST_TEST;
			st_reg.test_c <= cphy_pkg::RST_TEST;
			st_reg.irq_en <= cphy_pkg::RST_IRQ_EN;
			st_reg.tx_out <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// zero-wait slave: every transfer completes in one data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_reg.rdata;
	assign phy_tx_in = st_reg.tx_out;
	// R05 enable leaves shutdown
	// R06 zero keeps shutdown
	assign phy_on = st_reg.ctrl[cphy_pkg::POS_PHY_ON];
	assign termination_bias_on = st_reg.bias_oe;
	assign termination_bias_oe = st_reg.bias_oe;
	assign wake_rx_enable = st_reg.wake_en;
	// R10 filter code passed to front end
	assign wake_filter_sel = st_reg.ctrl[cphy_pkg::POS_WAKE_SEL +: 2];
	// R12 slew code passed unchanged; reserved codes are software's duty
	assign slew_sel = st_reg.ctrl[cphy_pkg::POS_SLEW +: 3];
	assign factory_test_a = st_reg.test_a;
	assign factory_test_b = st_reg.test_b;
	assign factory_test_c = st_reg.test_c;
	assign irq = st_reg.irq;
endmodule
`default_nettype wire

/* hdl/cphy_sync.sv */
// cphy_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes: levels are quasi-static relative to hclk, bits are independent.
`timescale 1ns/100ps
`default_nettype none
module cphy_sync #(
	parameter int W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	cphy_sync_if.sync sif
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} cphy_sync_state_t;
	cphy_sync_state_t st_reg;
	cphy_sync_state_t st_next;
	always_comb begin
		st_next.meta = sif.raw;
		st_next.stable = st_reg.meta;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign sif.synced = st_reg.stable;
endmodule
`default_nettype wire

/* pkg/cphy_pkg.sv */
// cphy_pkg: register map, field positions and reset values of the
// transceiver control register bank.
// assumes: AHB-Lite slave with 32-bit data, one register per word.
package cphy_pkg;
	localparam int ADDR_W = 8;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_PORT_DATA = 3'h0;
	localparam logic [2:0] IDX_PHY_CONTROL = 3'h1;
	localparam logic [2:0] IDX_FACTORY_TEST_A = 3'h2;
	localparam logic [2:0] IDX_PHY_STATUS = 3'h3;
	localparam logic [2:0] IDX_FACTORY_TEST_B = 3'h4;
	localparam logic [2:0] IDX_FACTORY_TEST_C = 3'h5;
	localparam logic [2:0] IDX_IRQ_ENABLE = 3'h6;
	localparam logic [2:0] IDX_IRQ_FLAGS = 3'h7;
	localparam int NUM_REGS = 8;
	// port_data fields
	localparam int POS_WAKE_RX = 7;
	localparam int POS_TX_DIRECT = 1;
	localparam int POS_RX = 0;
	// phy_control fields
	localparam int POS_PHY_ON = 7;
	localparam int POS_TERM_BIAS = 6;
	localparam int POS_WAKE_SEL = 4;
	localparam int POS_SLEW = 0;
	localparam logic [7:0] CTRL_WMASK = 8'h77;
	localparam logic [7:0] STATUS_MASK = 8'hF8;
	localparam logic [7:0] IRQ_EN_MASK = 8'h19;
	localparam logic [7:0] IRQ_FLAG_MASK = 8'hFB;
	// event bits of the status/flag layout
	localparam int POS_DT = 3;
	localparam int POS_HOC = 1;
	localparam int POS_LOC = 0;
	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic RST_TX_DIRECT = 1'b1;
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_TEST = 8'h00;
	localparam logic [2:0] SLEW_RSVD_A = 3'h3;
	localparam logic [2:0] SLEW_RSVD_B = 3'h7;
	localparam logic [1:0] WAKE_OFF = 2'h0;
	localparam logic [1:0] WAKE_MASK1 = 2'h1;
	localparam logic [1:0] WAKE_NOFILT = 2'h2;
	localparam logic [1:0] WAKE_MASK2 = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* pkg/cphy_sync_if.sv */
// cphy_sync_if: group of raw front-end levels and their synchronised copies.
// assumes: one clock domain on the consumer side.
`timescale 1ns/100ps
`default_nettype none
interface cphy_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface
`default_nettype wire

/* tb/cphy_fe_model.sv */
// cphy_fe_model: front end as plain levels, quiet bus loopback.
// assumes: level inputs only, wake level set by the bench.
`timescale 1ns/100ps
`default_nettype none
module cphy_fe_model (
	input wire logic phy_on,
	input wire logic phy_tx_in,
	input wire logic wake_rx_enable,
	input wire logic wake_lvl,
	output logic phy_rx_out,
	output logic wake_rx_out
);
	assign phy_rx_out = phy_on ? phy_tx_in : 1'b1;
	assign wake_rx_out = wake_rx_enable ? wake_lvl : 1'b1;
endmodule
`default_nettype wire

/* tb/cphy_regs_chk.sv */
// cphy_regs_chk: port-level properties of the register bank.
// assumes: bound to cphy_regs, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module cphy_regs_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [cphy_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic phy_tx_in,
	input wire logic phy_on,
	input wire logic termination_bias_on,
	input wire logic termination_bias_oe,
	input wire logic wake_rx_enable,
	input wire logic [1:0] wake_filter_sel,
	input wire logic [2:0] slew_sel,
	input wire logic irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic acc;
	assign acc = hsel && hready && htrans == cphy_pkg::HTRANS_NONSEQ;
	a_ctrl_write: assert property (acc && hwrite && haddr[4:2] == 3'h1
		|=> ##1 {wake_filter_sel, slew_sel} ==
		{$past(hwdata[5:4]), $past(hwdata[2:0])}) else $error("ctrl write");
	a_phy_on_set: assert property (acc && hwrite && haddr[4:2] == 3'h1
		|=> hwdata[7] |=> phy_on) else $error("enable not set");
	a_phy_on_keep: assert property (phy_on |=> phy_on)
		else $error("enable cleared");
	a_off_recessive: assert property (!phy_on && $past(!phy_on)
		|-> phy_tx_in) else $error("dominant in shutdown");
	a_bias_gate: assert property (termination_bias_oe == termination_bias_on
		&& (!termination_bias_on || phy_on)) else $error("bias pin");
	a_wake_gate: assert property ($rose(wake_rx_enable)
		|-> phy_on && wake_filter_sel != 2'h0) else $error("wake enable");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus response");
	a_read_zeros: assert property (acc && !hwrite
		|=> hrdata[31:8] == 24'h0) else $error("upper read bits");
	c_on: cover property ($rose(phy_on));
	c_irq: cover property ($rose(irq));
	c_dom: cover property (phy_on && !phy_tx_in);
endmodule
bind cphy_regs cphy_regs_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .phy_tx_in,
	.phy_on, .termination_bias_on, .termination_bias_oe, .wake_rx_enable,
	.wake_filter_sel, .slew_sel, .irq);
`default_nettype wire

/* tb/cphy_regs_tb_top.sv */
// cphy_regs_tb_top: bench with a register and pin model of the bank.
// assumes: hready fed back from hreadyout, 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module cphy_regs_tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00, fta, ftb, ftc;
	logic [1:0] htrans = 2'h0, oc = 2'h0, wfs;
	logic [2:0] hsize = cphy_pkg::HSIZE_WORD, slew;
	logic [31:0] hwdata = 32'h0, hrdata, lf = 32'h213E;
	logic hreadyout, hresp, special_mode = 1'b0, tx_from_port = 1'b0;
	logic can_tx_in = 1'b1, wake_lvl = 1'b1, phy_rx_out, wake_rx_out, irq;
	logic phy_tx_in, phy_on, bon, boe, wake_rx_enable;
	logic [4:0] flt = 5'h0;
	int n_fail = 0, checks = 0, cyc = 0;
	int m_ctrl = 0, m_p1 = 1, m_ien = 0, m_fl = 0, m_ft = 0;
	always #25 hclk = ~hclk;
	cphy_regs dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.special_mode, .tx_from_port, .can_tx_in, .phy_rx_out, .wake_rx_out,
		.bus_fault_status(flt), .over_current(oc), .phy_tx_in, .phy_on,
		.termination_bias_on(bon), .termination_bias_oe(boe), .wake_rx_enable,
		.wake_filter_sel(wfs), .slew_sel(slew), .factory_test_a(fta),
		.factory_test_b(ftb), .factory_test_c(ftc), .irq);
	cphy_fe_model fe_u (.phy_on, .phy_tx_in, .wake_rx_enable, .wake_lvl,
		.phy_rx_out, .wake_rx_out);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
	endfunction
	function automatic logic ex_tx();
		return !m_ctrl[7] | (tx_from_port ? m_p1[0] : can_tx_in);
	endfunction
	function automatic logic [7:0] ex_rd(input int i);
		logic wk;
		wk = (m_ctrl[7] && m_ctrl[5:4] != 0) ? wake_lvl : 1'b1;
		case (i)
			0: return {wk, 5'h0, m_p1[0], ex_tx()};
			1: return m_ctrl[7:0];
			2: return m_ft[7:0];
			3: return {flt, 3'h0};
			6: return m_ien[7:0];
			7: return m_fl[7:0];
			default: return 8'h00;
		endcase
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
			n_fail++;
		end
	endtask
	task automatic bus(input int i, input logic w, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= 8'(4 * i);
		htrans <= cphy_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		logic [31:0] r;
		bus(i, 1'b1, {24'hFFFFFF, d}, r);
		if (i == 0) m_p1 = d[1];
		if (i == 1) m_ctrl = {m_ctrl[7] | d[7], d[6:0] & 7'h77};
		if (i == 2 && special_mode) m_ft = d;
		if (i == 6) m_ien = d & 8'h19;
		if (i == 7) m_fl = m_fl & ~d;
		@(posedge hclk);
	endtask
	task automatic rdchk(input int i);
		logic [31:0] r;
		bus(i, 1'b0, 32'h0, r);
		chk("read", {24'h0, ex_rd(i)}, r);
	endtask
	task automatic outs();
		logic on, ie;
		repeat (2) @(posedge hclk);
		on = m_ctrl[7];
		ie = (|m_fl[7:4] & m_ien[4]) | (m_fl[3] & m_ien[3])
			| (|m_fl[1:0] & m_ien[0]);
		chk("pins", {on, {2{on & m_ctrl[6]}}, on & |m_ctrl[5:4], m_ctrl[5:4],
			m_ctrl[2:0], ex_tx(), ie, m_ft[7:0]},
			{phy_on, bon, boe, wake_rx_enable, wfs, slew, phy_tx_in, irq, fta});
		chk("test b c", 32'h0, {ftb, ftc});
	endtask
	task automatic results();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		// level synchronisers need two edges before port reads settle
		repeat (3) @(posedge hclk);
		for (int i = 0; i < 8; i++) rdchk(i);
		wr(2, 8'hA5);
		rdchk(2);
		special_mode <= 1'b1;
		wr(2, 8'h5A);
		rdchk(2);
		special_mode <= 1'b0;
		for (int j = 0; j < 6; j++) begin
			lf = nx(lf);
			wr(1, {1'b0, lf[0], 2'(j % 4), 1'b0, 3'(j < 3 ? j : j + 1)});
			outs();
			rdchk(1);
		end
		wr(1, 8'hE8);
		outs();
		rdchk(1);
		wr(1, 8'h12);
		outs();
		tx_from_port <= 1'b1;
		for (int j = 0; j < 6; j++) begin
			lf = nx(lf);
			wake_lvl <= lf[1];
			can_tx_in <= lf[2];
			if (j == 3) tx_from_port <= 1'b0;
			if (j < 3) wr(0, lf[7:0]);
			repeat (4) @(posedge hclk);
			outs();
			rdchk(0);
		end
		oc <= 2'h2;
		m_fl = 2;
		repeat (5) @(posedge hclk);
		outs();
		wr(6, 8'hFF);
		outs();
		oc <= 2'h0;
		repeat (5) @(posedge hclk);
		wr(7, 8'h00);
		rdchk(7);
		wr(7, 8'h02);
		outs();
		flt <= 5'h11;
		m_fl = 8'h88;
		repeat (5) @(posedge hclk);
		rdchk(3);
		outs();
		wr(7, 8'hFF);
		rdchk(7);
		results();
	end
endmodule
`default_nettype wire
